/* atrb_bank.sv */
// Purpose: four 8-bit trim registers with enable-gated analog trim outputs
// Assumes: req is synchronous to ref_clk and lasts one cycle per access
// Notes:   por_n models a full power-down; only it releases the sleep bandgap freeze
//          trim outputs carry raw codes; the analog cells turn them into steps
//          a disabled function other than a frozen sleep trim drives its zero code, which is its default setting
//          there is no low-power input, so the registers simply hold while idle
//
// How it works
// - trims at 0xF0-0xF3 in both windows
// - every trim register readable and writable
// - LIN slope applied only when enabled
// - LIN bit: zero default, one adjusted
// - watchdog code applied only when enabled
// - watchdog code mapping passed to clock
// - bandgap up/down honoured only when enabled
// - bit5 raises, bit4 lowers bandgap slope
// - current reference code gated by enable
// - current reference code mapping passed through
// - sleep trim accepted only when enabled
// - lock freezes sleep analog trim
// - reset clears digital copy, not lock
// - sleep code mapping, 000 default
// - ADC offset code gated by enable
// - ADC offset code in bits 6-4
// - spare bits are storage only, except sleep bits 7:5, which stay zero
// - contents kept in low-power mode
// - reset returns registers to defaults
`timescale 1ns/100ps
`include "atrb_consts.svh"

module atrb_bank
  import atrb_pkg::*;
(
  // clock and resets
  input  wire logic          ref_clk,
  input  wire logic          arst_n,
  input  wire logic          por_n,
  // die-to-die register access
  input  wire atrb_req_type  req,
  output logic [7:0]         rdata,
  output logic               rvalid,
  // analog trim outputs
  output atrb_trim_type      trim
);

  // reset release, and a separate power-on release for the frozen analog copy
  // each reset asserts at once but leaves through two flops, so no register
  // sees its reset end close to a clock edge
  // only the second flop of each pair is read outside this pair
  logic       rst_meta_q;
  logic       rst_sync_q;
  logic       por_meta_q;
  logic       por_sync_q;

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge ref_clk or negedge por_n)
  begin
    if (!por_n)
    begin
      por_meta_q <= 1'b0;
      por_sync_q <= 1'b0;
    end
    else
    begin
      por_meta_q <= 1'b1;
      por_sync_q <= por_meta_q;
    end
  end

  wire rst_n = rst_sync_q;
  wire por_s = por_sync_q;

  // address decode: both windows reach the same four registers
  // an access outside the four offsets is ignored on write and reads zero
  function automatic logic hit(input logic [15:0] a, input logic [7:0] ofs);
    logic [15:0] blk_addr;
    logic [15:0] nbk_addr;
    blk_addr = `ATRB_BASE_BLOCKING + {8'h00, ofs};
    nbk_addr = `ATRB_BASE_NONBLOCKING + {8'h00, ofs};
    hit      = (a == blk_addr) || (a == nbk_addr);
  endfunction : hit

  wire hit_lin  = req.sel && hit(req.addr, `ATRB_OFS_LIN_WDOG);
  wire hit_bg   = req.sel && hit(req.addr, `ATRB_OFS_BG_IREF);
  wire hit_slp  = req.sel && hit(req.addr, `ATRB_OFS_SLEEP_BG);
  wire hit_adc  = req.sel && hit(req.addr, `ATRB_OFS_ADC_OFS);
  wire any_hit  = hit_lin || hit_bg || hit_slp || hit_adc;

  // strobes last one cycle; the bus raises sel once per access
  // a write strobe needs a hit, so stray addresses never touch a register
  wire rd_strobe = req.sel && !req.wr;
  wire wr_lin    = req.wr && hit_lin;
  wire wr_bg     = req.wr && hit_bg;
  wire wr_slp    = req.wr && hit_slp;
  wire wr_adc    = req.wr && hit_adc;

  // digital copies of the four registers
  // reset values are all zero, so every trim function starts disabled
  logic [7:0] lin_wdog_q;
  logic [7:0] bg_iref_q;
  logic [7:0] sleep_bg_q;
  logic [7:0] adc_ofs_q;

  // named fields; codes other than the sleep code are stored and read back even while their enable is clear
  wire       lin_slope_trim_en     = lin_wdog_q[`ATRB_BIT_LIN_EN];
  wire       lin_slope_adjust      = lin_wdog_q[`ATRB_BIT_LIN_ADJ];
  wire       wdog_clk_trim_en      = lin_wdog_q[`ATRB_BIT_WDOG_EN];
  wire [2:0] wdog_clk_trim_code    = lin_wdog_q[2:0];
  wire       main_bg_trim_en       = bg_iref_q[`ATRB_BIT_BG_EN];
  wire       main_bg_slope_up      = bg_iref_q[`ATRB_BIT_BG_UP];
  wire       main_bg_slope_down    = bg_iref_q[`ATRB_BIT_BG_DN];
  wire       cur_ref_trim_en       = bg_iref_q[`ATRB_BIT_IREF_EN];
  wire [2:0] cur_ref_trim_code     = bg_iref_q[2:0];
  wire       sleep_ref_trim_en     = sleep_bg_q[`ATRB_BIT_SLP_EN];
  wire       sleep_ref_trim_freeze = sleep_bg_q[`ATRB_BIT_SLP_LOCK];
  wire [2:0] sleep_ref_trim_code   = sleep_bg_q[2:0];
  wire       adc_ofs_trim_en       = adc_ofs_q[`ATRB_BIT_ADC_EN];
  wire [2:0] adc_ofs_trim_code     = adc_ofs_q[6:4];

  // a sleep register write lands only when its enable is already set or being set;
  // otherwise only the enable bit itself is taken, and bits 7:5 always stay zero
  function automatic logic [7:0] slp_next(input logic [7:0] cur, input logic [7:0] wd);
    logic en_cur;
    logic en_new;
    en_cur = cur[`ATRB_BIT_SLP_EN];
    en_new = wd[`ATRB_BIT_SLP_EN];
    if (en_cur || en_new)
      slp_next = wd & `ATRB_SLEEP_BG_MASK;
    else
      slp_next = (cur & 8'hEF) | {3'h0, en_new, 4'h0};
  endfunction : slp_next

  wire [7:0] slp_wr_val = slp_next(sleep_bg_q, req.wdata);

  // first register; no low-power input exists, so contents hold whenever idle
  // one short process per register keeps each write path easy to follow
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lin_wdog_q <= `ATRB_RST_LIN_WDOG;
    else if (wr_lin)
      lin_wdog_q <= req.wdata;
  end

  // second register; spare bit 6 is stored and read back only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bg_iref_q <= `ATRB_RST_BG_IREF;
    else if (wr_bg)
      bg_iref_q <= req.wdata;
  end

  // third register; device reset clears this digital copy only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_bg_q <= `ATRB_RST_SLEEP_BG;
    else if (wr_slp)
      sleep_bg_q <= slp_wr_val;
  end

  // fourth register; the spare enable and bits 2:0 are storage only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      adc_ofs_q <= `ATRB_RST_ADC_OFS;
    else if (wr_adc)
      adc_ofs_q <= req.wdata;
  end

  // analog sleep trim: follows the digital copy until locked, then frozen to power-down
  // a write after the lock still changes the digital copy, never the analog one
  atrb_slp_state_type slp_state_q;
  atrb_slp_state_type slp_state_d;
  logic [2:0]         slp_analog_q;

  wire slp_armed = sleep_ref_trim_en;
  wire slp_lock  = slp_armed && sleep_ref_trim_freeze;

  // next-state logic; the frozen state has no way out but power-on
  always_comb
  begin
    case (slp_state_q)
      ATRB_SLP_OPEN:   slp_state_d = slp_lock ? ATRB_SLP_FROZEN : ATRB_SLP_OPEN;
      ATRB_SLP_FROZEN: slp_state_d = ATRB_SLP_FROZEN;
      default:         slp_state_d = ATRB_SLP_OPEN;
    endcase
  end

  // reset only by power-on so device reset cannot undo a lock
  always_ff @(posedge ref_clk or negedge por_s)
  begin
    if (!por_s)
    begin
      slp_state_q  <= ATRB_SLP_OPEN;
      slp_analog_q <= 3'h0;
    end
    else
    begin
      slp_state_q <= slp_state_d;
      if (slp_state_q == ATRB_SLP_OPEN)
        slp_analog_q <= slp_armed ? sleep_bg_q[2:0] : 3'h0;
    end
  end

  // enable gating; a disabled function falls back to its default code of zero
  // the same two helpers serve every function but the sleep trim, so the gating cannot drift apart
  function automatic logic gate1(input logic en, input logic v);
    gate1 = en & v;
  endfunction : gate1

  function automatic logic [2:0] gate3(input logic en, input logic [2:0] c);
    gate3 = en ? c : 3'h0;
  endfunction : gate3

  // gated trims; percentages are decoded in the analog cells, so codes pass raw
  // the bandgap up and down bits are passed as set, even if both are set at once
  wire       lin_adj_d   = gate1(lin_slope_trim_en, lin_slope_adjust);
  wire [2:0] wdog_code_d = gate3(wdog_clk_trim_en, wdog_clk_trim_code);
  wire       bg_up_d     = gate1(main_bg_trim_en, main_bg_slope_up);
  wire       bg_dn_d     = gate1(main_bg_trim_en, main_bg_slope_down);
  wire [2:0] iref_code_d = gate3(cur_ref_trim_en, cur_ref_trim_code);
  wire [2:0] adc_code_d  = gate3(adc_ofs_trim_en, adc_ofs_trim_code);
  wire       slp_frz_d   = (slp_state_q == ATRB_SLP_FROZEN);

  // read mux; unmapped addresses read zero
  // rdata is forced to zero outside a read so a stale byte never lingers
  wire [7:0] rd_mux = hit_lin ? lin_wdog_q :
                      hit_bg  ? bg_iref_q  :
                      hit_slp ? sleep_bg_q :
                      hit_adc ? adc_ofs_q  : 8'h00;

  // analog-facing copies held in the device-reset domain
  logic       lin_adj_q;
  logic [2:0] wdog_code_q;
  logic       bg_up_q;
  logic       bg_dn_q;
  logic [2:0] iref_code_q;
  logic [2:0] adc_code_q;
  // sleep-facing copies held in the power-on domain, so device reset keeps a lock
  logic [2:0] slp_code_q;
  logic       slp_frz_q;

  // read answer; rdata stands for one cycle only
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else
      rdata <= rd_strobe ? rd_mux : 8'h00;
  end

  // rvalid pulses for a read that hit one of the four registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rvalid <= 1'b0;
    else
      rvalid <= rd_strobe && any_hit;
  end

  // enable-gated trims; each lags its register by one cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      lin_adj_q <= 1'b0;
    else
      lin_adj_q <= lin_adj_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      wdog_code_q <= 3'h0;
    else
      wdog_code_q <= wdog_code_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bg_up_q <= 1'b0;
    else
      bg_up_q <= bg_up_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      bg_dn_q <= 1'b0;
    else
      bg_dn_q <= bg_dn_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      iref_code_q <= 3'h0;
    else
      iref_code_q <= iref_code_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      adc_code_q <= 3'h0;
    else
      adc_code_q <= adc_code_d;
  end

  // a locked sleep trim survives device reset; only power-on clears it
  always_ff @(posedge ref_clk or negedge por_s)
  begin
    if (!por_s)
    begin
      slp_code_q <= 3'h0;
      slp_frz_q  <= 1'b0;
    end
    else
    begin
      slp_code_q <= slp_analog_q;
      slp_frz_q  <= slp_frz_d;
    end
  end

  // sleep fields come from the power-on flops, the rest from the device-reset flops;
  // the port is a plain gathering of flop outputs, with no logic in between
  assign trim = {lin_adj_q, wdog_code_q, bg_up_q, bg_dn_q, iref_code_q, slp_code_q, slp_frz_q, adc_code_q};

endmodule : atrb_bank

/* atrb_consts.svh */
// Purpose: offsets, field positions, reset values for the analog trim register bank
// Assumes: byte-wide die-to-die register access, offsets relative to a window base
// Notes:   definitions only
`ifndef ATRB_CONSTS_SVH
`define ATRB_CONSTS_SVH

`define ATRB_BASE_BLOCKING    16'h0200
`define ATRB_BASE_NONBLOCKING 16'h0300
`define ATRB_OFS_LIN_WDOG     8'hF0
`define ATRB_OFS_BG_IREF      8'hF1
`define ATRB_OFS_SLEEP_BG     8'hF2
`define ATRB_OFS_ADC_OFS      8'hF3

`define ATRB_RST_LIN_WDOG     8'h00
`define ATRB_RST_BG_IREF      8'h00
`define ATRB_RST_SLEEP_BG     8'h00
`define ATRB_RST_ADC_OFS      8'h00
`define ATRB_SLEEP_BG_MASK    8'h1F

`define ATRB_BIT_LIN_EN       7
`define ATRB_BIT_LIN_ADJ      6
`define ATRB_BIT_WDOG_EN      5
`define ATRB_BIT_BG_EN        7
`define ATRB_BIT_BG_UP        5
`define ATRB_BIT_BG_DN        4
`define ATRB_BIT_IREF_EN      3
`define ATRB_BIT_SLP_EN       4
`define ATRB_BIT_SLP_LOCK     3
`define ATRB_BIT_ADC_EN       7
`define ATRB_BIT_SPARE_EN     3

`endif

/* atrb_pkg.sv */
// Purpose: types for the analog trim register bank
// Assumes: nothing beyond the constants header
// Notes:   trim codes are passed raw; the analog side interprets them
package atrb_pkg;

  // bus request from the die-to-die slave
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } atrb_req_type;

  // gated trims presented to the analog circuits
  typedef struct packed {
    logic       lin_slope_adjust;
    logic [2:0] wdog_clk_trim_code;
    logic       main_bg_slope_up;
    logic       main_bg_slope_down;
    logic [2:0] cur_ref_trim_code;
    logic [2:0] sleep_ref_trim_code;
    logic       sleep_ref_trim_freeze;
    logic [2:0] adc_ofs_trim_code;
  } atrb_trim_type;

  typedef enum logic [1:0] {
    ATRB_SLP_OPEN   = 2'b01,
    ATRB_SLP_FROZEN = 2'b10
  } atrb_slp_state_type;

endpackage : atrb_pkg

/* atrb_bank_assertions.sv */
// Purpose: port checks for the trim register bank
// Assumes: one access per request cycle
// Notes:   analog percentages are not decoded here
`timescale 1ns/100ps
`include "atrb_consts.svh"
module atrb_bank_checker
  import atrb_pkg::*;
(
  // clock and resets
  input wire logic          ref_clk,
  input wire logic          arst_n,
  input wire logic          por_n,
  // bus and outputs
  input wire atrb_req_type  req,
  input wire logic [7:0]    rdata,
  input wire logic          rvalid,
  input wire atrb_trim_type trim
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // address decode in both windows
  wire base_ok = req.addr[15:8] == 8'h02 || req.addr[15:8] == 8'h03;
  wire hit     = req.sel && base_ok && req.addr[7:2] == 6'h3C;
  logic [7:0] w1_q;
  logic [7:0] w2_q;
  // write data two cycles back, when trim shows it
  always_ff @(posedge ref_clk)
  begin
    w1_q <= req.wdata;
    w2_q <= w1_q;
  end
  sequence wr_to(logic [7:0] o);
    req.sel && req.wr && base_ok && req.addr[7:0] == o;
  endsequence
  rd_valid_a: assert property (hit && !req.wr |=> rvalid)
    else $error("read hit gave no answer");
  quiet_bus_a: assert property (!hit || req.wr |=> !rvalid && rdata == 8'h00)
    else $error("answer without a mapped read");
  lin_gate_a: assert property (wr_to(`ATRB_OFS_LIN_WDOG) ##2 1 |-> trim.lin_slope_adjust == &w2_q[7:6])
    else $error("lin slope not gated");
  wdog_gate_a: assert property (wr_to(`ATRB_OFS_LIN_WDOG) ##2 1 |->
    trim.wdog_clk_trim_code == (w2_q[5] ? w2_q[2:0] : 3'h0))
    else $error("watchdog code not gated");
  bg_gate_a: assert property (wr_to(`ATRB_OFS_BG_IREF) ##2 1 |->
    {trim.main_bg_slope_up, trim.main_bg_slope_down} == (w2_q[7] ? w2_q[5:4] : 2'b00))
    else $error("bandgap slope not gated");
  iref_gate_a: assert property (wr_to(`ATRB_OFS_BG_IREF) ##2 1 |->
    trim.cur_ref_trim_code == (w2_q[3] ? w2_q[2:0] : 3'h0))
    else $error("current ref code not gated");
  adc_gate_a: assert property (wr_to(`ATRB_OFS_ADC_OFS) ##2 1 |->
    trim.adc_ofs_trim_code == (w2_q[7] ? w2_q[6:4] : 3'h0))
    else $error("adc offset code not gated");
  freeze_hold_a: assert property (disable iff (!arst_n || !por_n)
    trim.sleep_ref_trim_freeze && $past(trim.sleep_ref_trim_freeze) |-> $stable(trim.sleep_ref_trim_code))
    else $error("frozen sleep code moved");
endmodule : atrb_bank_checker
bind atrb_bank atrb_bank_checker i_chk (.ref_clk(ref_clk), .arst_n(arst_n), .por_n(por_n),
  .req(req), .rdata(rdata), .rvalid(rvalid), .trim(trim));

/* atrb_mcu_model.sv */
// Purpose: controller die issuing byte accesses
// Assumes: one-cycle strobe, answer one cycle later
// Notes:   drives on the falling edge
`timescale 1ns/100ps
module atrb_mcu_model
  import atrb_pkg::*;
(
  // clock
  input wire logic       ref_clk,
  // request and answer
  output atrb_req_type   req,
  input wire logic [7:0] rdata
);
  initial req = '{1'b0, 1'b1, 16'hFFFF, 8'hFF};
  // idle fields carry the inverse so a stale value never looks driven
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk);
    req = '{1'b1, w, a, d};
    @(negedge ref_clk);
    q   = rdata;
    req = '{1'b0, ~w, ~a, ~d};
  endtask : acc
endmodule : atrb_mcu_model

/* tb_top.sv */
// Purpose: register and trim tests of the bank
// Assumes: controller model drives all accesses
// Notes:   trim checked after the update latency
`timescale 1ns/100ps
module tb_top;
  import atrb_pkg::*;
  logic          ref_clk = 0;
  logic          arst_n  = 0;
  logic          por_n   = 0;
  atrb_req_type  req;
  logic [7:0]    rdata;
  logic          rvalid;
  atrb_trim_type trim;
  logic [7:0]    q;
  logic [7:0]    fv [4] = '{8'hFD, 8'h7F, 8'h1D, 8'hEF};
  int            miscompares = 0;
  int            n_compared  = 0;
  // 100 MHz clock
  initial forever #5 ref_clk = ~ref_clk;
  atrb_bank i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .por_n(por_n), .req(req),
    .rdata(rdata), .rvalid(rvalid), .trim(trim));
  atrb_mcu_model i_mcu (.ref_clk(ref_clk), .req(req), .rdata(rdata));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    i_mcu.acc(1'b0, a, 8'h00, q);
    chk($sformatf("rd %h", a), {8'h00, e}, {8'h00, q});
  endtask : rd
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    i_mcu.acc(1'b1, a, d, q);
  endtask : wr
  // device reset, optionally with a full power-down
  task automatic rst(input logic por);
    @(negedge ref_clk);
    arst_n = 0;
    por_n  = ~por;
    repeat (3) @(negedge ref_clk);
    arst_n = 1;
    por_n  = 1;
    repeat (4) @(negedge ref_clk);
  endtask : rst
  task automatic print_verdict;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  // watchdog, well beyond the fewer than a hundred cycles of the tests
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
  initial
  begin
    rst(1'b1);
    for (int i = 0; i < 8; i++)
      rd(16'h02F0 + 16'(i % 4) + (i > 3 ? 16'h0100 : 16'h0000), 8'h00);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      wr(16'h02F0 + 16'(i), i == 2 ? fv[i] & 8'hF7 : fv[i]);
    for (int i = 0; i < 4; i++)
      rd(16'h03F0 + 16'(i), i == 2 ? 8'h15 : fv[i]);
    chk("trim", trim, atrb_trim_type'{1'b1, 3'd5, 1'b0, 1'b0, 3'd7, 3'd5, 1'b0, 3'd6});
    $display("test load done");
    wr(16'h02F0, 8'h5D);
    wr(16'h02F1, 8'hB8);
    wr(16'h02F3, 8'h7F);
    wr(16'h01F0, 8'hFF);
    rd(16'h03F0, 8'h5D);
    rd(16'h02F4, 8'h00);
    rd(16'h04F0, 8'h00);
    chk("trim", trim, atrb_trim_type'{1'b0, 3'd0, 1'b1, 1'b1, 3'd0, 3'd5, 1'b0, 3'd0});
    $display("test gating done");
    wr(16'h02F2, 8'h1B);
    rd(16'h03F2, 8'h1B);
    wr(16'h02F2, 8'h16);
    repeat (3) @(negedge ref_clk);
    chk("freeze", {trim.sleep_ref_trim_code, trim.sleep_ref_trim_freeze}, 16'h0007);
    rst(1'b0);
    rd(16'h02F2, 8'h00);
    chk("freeze", {trim.sleep_ref_trim_code, trim.sleep_ref_trim_freeze}, 16'h0007);
    wr(16'h02F2, 8'hE7);
    rd(16'h02F2, 8'h00);
    rst(1'b1);
    chk("freeze", {trim.sleep_ref_trim_code, trim.sleep_ref_trim_freeze}, 16'h0000);
    $display("test lock done");
    print_verdict();
  end
endmodule : tb_top
